/* rtl/ethernet_rx_frame_status.sv */
// Receive frame status word, ready flags, flush and descriptor copy
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module ethernet_rx_frame_status
  import rx_status_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  // AXI4-Lite slave
  input  wire logic [31:0] s_axi_awaddr_in,
  input  wire logic        s_axi_awvalid_in,
  output logic             s_axi_awready_out,
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  input  wire logic        s_axi_wvalid_in,
  output logic             s_axi_wready_out,
  output logic [1:0]       s_axi_bresp_out,
  output logic             s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  input  wire logic [31:0] s_axi_araddr_in,
  input  wire logic        s_axi_arvalid_in,
  output logic             s_axi_arready_out,
  output logic [31:0]      s_axi_rdata_out,
  output logic [1:0]       s_axi_rresp_out,
  output logic             s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in,
  // PHY receive pins
  input  wire logic        rx_dv_pin_in,
  input  wire logic        rx_er_pin_in,
  input  wire logic        crs_pin_in,
  // Receive function, same clock
  input  wire logic        frame_end_in,
  input  wire logic [15:0] frame_bytes_in,
  input  wire logic        fcs_bad_in,
  input  wire logic [2:0]  extra_bits_in,
  input  wire logic        dest_broadcast_in,
  input  wire logic        dest_multicast_in,
  input  wire logic        sfd_missing_in,
  input  wire logic        fifo_full_in,
  input  wire logic        frame_drained_in,
  // Indications
  output logic             receive_word_ready_out,
  output logic             receive_fifo_level_out,
  output logic             buffer_complete_out,
  output logic             flush_frame_out,
  output logic             desc_write_out,
  output logic [15:0]      desc_status_out,
  output logic [15:0]      desc_length_out,
  output logic             irq_out
);
  phy_activity_if act ();

  phy_activity_tracker u_tracker (
    .clk_in       (clk_in),
    .rstn_in      (rstn_in),
    .rx_dv_pin_in (rx_dv_pin_in),
    .rx_er_pin_in (rx_er_pin_in),
    .crs_pin_in   (crs_pin_in),
    .act          (act.tracker)
  );

  logic [31:0]       status_reg;
  logic [CTRL_W-1:0] ctrl_reg;
  logic [IRQ_W-1:0]  irq_stat_reg;
  logic [IRQ_W-1:0]  irq_mask_reg;
  logic              dv_seen_reg;
  logic              ovf_seen_reg;
  logic              ready_reg;
  logic              complete_reg;
  logic              load_d_reg;
  logic              flush_reg;
  logic              desc_wr_reg;
  logic [15:0]       desc_status_reg;
  logic [15:0]       desc_length_reg;
  logic              irq_reg;

  logic [31:0]       status_next;
  logic              too_long;
  logic              too_short;
  logic              ovf_now;
  logic              code_err;
  logic              frame_bad;

  // AXI state
  logic              awready_reg;
  logic              wready_reg;
  logic              aw_full_reg;
  logic              w_full_reg;
  logic [31:0]       aw_addr_reg;
  logic [31:0]       w_data_reg;
  logic [3:0]        w_strb_reg;
  logic              bvalid_reg;
  logic [1:0]        bresp_reg;
  logic              arready_reg;
  logic              rvalid_reg;
  logic [31:0]       rdata_reg;
  logic [1:0]        rresp_reg;
  logic              wr_go;
  logic              rd_go;
  logic              wr_hit;
  logic              rd_hit;
  logic [31:0]       rd_mux;
  logic              irq_rd_clear;

  // Frame classification
  assign ovf_now   = fifo_full_in && act.frame_active;
  assign code_err  = act.code_err_seen || act.code_err_now;
  assign too_long  = frame_bytes_in > MAX_FRAME_BYTES; // RL14
  assign too_short = frame_bytes_in < MIN_FRAME_BYTES; // RL15

  // Dribble blocks the frame like the other error causes
  assign frame_bad = fcs_bad_in
                  || (extra_bits_in != 3'h0)
                  || code_err
                  || (too_long && !ctrl_reg[ACC_LONG_BIT])
                  || (too_short && !ctrl_reg[ACC_SHORT_BIT])
                  || ovf_seen_reg || ovf_now; // RL11

  always_comb begin
    status_next                 = STATUS_RESET;
    status_next[31:COUNT_LSB]   = frame_bytes_in; // RL3
    status_next[CARRIER_BIT]    = act.carrier_seen; // RL5
    status_next[DATA_VIOL_BIT]  = dv_seen_reg; // RL6
    status_next[GOOD_BIT]       = !frame_bad; // RL7
    status_next[BCAST_BIT]      = dest_broadcast_in; // RL8
    status_next[MCAST_BIT]      = dest_multicast_in; // RL9
    status_next[FCS_BIT]        = fcs_bad_in; // RL10
    status_next[DRIBBLE_BIT]    = extra_bits_in != 3'h0; // RL12
    status_next[CODE_BIT]       = code_err; // RL13
    status_next[LONG_BIT]       = too_long; // RL14
    status_next[SHORT_BIT]      = too_short; // RL15
    status_next[OVF_BIT]        = ovf_seen_reg || ovf_now; // RL16
  end

  assign act.clear_seen = frame_end_in;

  // Status word, loaded once per completed frame
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      status_reg <= STATUS_RESET; // RL17
    end else if (frame_end_in) begin
      status_reg <= status_next; // RL1
    end
  end

  // Sticky history; a same-cycle violation is kept for the next frame
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      dv_seen_reg <= 1'b0;
    end else begin
      dv_seen_reg <= sfd_missing_in || (dv_seen_reg && !frame_end_in); // RL6
    end
  end

  // Overflow belongs to the frame in flight
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ovf_seen_reg <= 1'b0;
    end else if (frame_end_in) begin
      ovf_seen_reg <= 1'b0;
    end else if (ovf_now) begin
      ovf_seen_reg <= 1'b1; // RL16
    end
  end

  // Ready indications: up for good frames until drained
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ready_reg <= 1'b0;
    end else if (frame_end_in && !frame_bad) begin
      ready_reg <= 1'b1; // RL7 RL8 RL9
    end else if (frame_drained_in) begin
      ready_reg <= 1'b0; // RL7
    end
  end

  // Flush pulse in the load cycle; ready never rises for these
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      flush_reg <= 1'b0;
    end else begin
      flush_reg <= frame_end_in && frame_bad; // RL11
    end
  end

  // Complete follows the load by one edge, so the word is already valid
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      load_d_reg   <= 1'b0;
      complete_reg <= 1'b0;
    end else begin
      load_d_reg   <= frame_end_in;
      complete_reg <= load_d_reg; // RL1
    end
  end

  // Descriptor copy in DMA mode
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      desc_wr_reg     <= 1'b0;
      desc_status_reg <= STATUS_RESET[15:0];
      desc_length_reg <= STATUS_RESET[31:16];
    end else begin
      desc_wr_reg <= frame_end_in && ctrl_reg[DMA_MODE_BIT];
      if (frame_end_in && ctrl_reg[DMA_MODE_BIT]) begin
        desc_status_reg <= status_next[15:0]; // RL2
        desc_length_reg <= status_next[31:COUNT_LSB]; // RL4
      end
    end
  end

  // Interrupt status: read clears, a new event in that cycle wins
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      irq_stat_reg <= '0;
    end else begin
      irq_stat_reg[IRQ_DONE_BIT]  <= complete_reg
                                   || (irq_stat_reg[IRQ_DONE_BIT] && !irq_rd_clear);
      irq_stat_reg[IRQ_GOOD_BIT]  <= (frame_end_in && !frame_bad)
                                   || (irq_stat_reg[IRQ_GOOD_BIT] && !irq_rd_clear);
      irq_stat_reg[IRQ_FLUSH_BIT] <= flush_reg
                                   || (irq_stat_reg[IRQ_FLUSH_BIT] && !irq_rd_clear);
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // Write channel: address and data taken in either order
  assign wr_go  = aw_full_reg && w_full_reg && !bvalid_reg;
  assign wr_hit = (aw_addr_reg == STATUS_ADDR) || (aw_addr_reg == CTRL_ADDR)
               || (aw_addr_reg == IRQ_STAT_ADDR) || (aw_addr_reg == IRQ_MASK_ADDR);

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      awready_reg <= 1'b1;
      aw_full_reg <= 1'b0;
      aw_addr_reg <= 32'h0000_0000;
    end else begin
      if (awready_reg && s_axi_awvalid_in) begin
        awready_reg <= 1'b0;
        aw_full_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr_in;
      end else if (wr_go) begin
        aw_full_reg <= 1'b0;
      end else if (bvalid_reg && s_axi_bready_in) begin
        awready_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wready_reg <= 1'b1;
      w_full_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
    end else begin
      if (wready_reg && s_axi_wvalid_in) begin
        wready_reg <= 1'b0;
        w_full_reg <= 1'b1;
        w_data_reg <= s_axi_wdata_in;
        w_strb_reg <= s_axi_wstrb_in;
      end else if (wr_go) begin
        w_full_reg <= 1'b0;
      end else if (bvalid_reg && s_axi_bready_in) begin
        wready_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= wr_hit ? RESP_OKAY : RESP_DECERR;
    end else if (bvalid_reg && s_axi_bready_in) begin
      bvalid_reg <= 1'b0;
    end
  end

  // Status and interrupt status are read-only; writes there are dropped
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ctrl_reg     <= CTRL_RESET;
      irq_mask_reg <= MASK_RESET;
    end else if (wr_go && w_strb_reg[0]) begin
      if (aw_addr_reg == CTRL_ADDR) begin
        ctrl_reg <= w_data_reg[CTRL_W-1:0];
      end
      if (aw_addr_reg == IRQ_MASK_ADDR) begin
        irq_mask_reg <= w_data_reg[IRQ_W-1:0];
      end
    end
  end

  // Read channel
  assign rd_go        = arready_reg && s_axi_arvalid_in;
  assign irq_rd_clear = rd_go && (s_axi_araddr_in == IRQ_STAT_ADDR);

  always_comb begin
    rd_hit = 1'b1;
    rd_mux = 32'h0000_0000;
    case (s_axi_araddr_in)
      STATUS_ADDR:   rd_mux = status_reg; // RL17
      CTRL_ADDR:     rd_mux[CTRL_W-1:0] = ctrl_reg;
      IRQ_STAT_ADDR: rd_mux[IRQ_W-1:0] = irq_stat_reg;
      IRQ_MASK_ADDR: rd_mux[IRQ_W-1:0] = irq_mask_reg;
      default:       rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
      rresp_reg   <= RESP_OKAY;
    end else if (rd_go) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b1;
      rdata_reg   <= rd_mux;
      rresp_reg   <= rd_hit ? RESP_OKAY : RESP_DECERR;
    end else if (rvalid_reg && s_axi_rready_in) begin
      rvalid_reg  <= 1'b0;
      arready_reg <= 1'b1;
    end
  end

  assign s_axi_awready_out      = awready_reg;
  assign s_axi_wready_out       = wready_reg;
  assign s_axi_bvalid_out       = bvalid_reg;
  assign s_axi_bresp_out        = bresp_reg;
  assign s_axi_arready_out      = arready_reg;
  assign s_axi_rvalid_out       = rvalid_reg;
  assign s_axi_rdata_out        = rdata_reg;
  assign s_axi_rresp_out        = rresp_reg;
  assign receive_word_ready_out = ready_reg;
  assign receive_fifo_level_out = ready_reg;
  assign buffer_complete_out    = complete_reg;
  assign flush_frame_out        = flush_reg;
  assign desc_write_out         = desc_wr_reg;
  assign desc_status_out        = desc_status_reg;
  assign desc_length_out        = desc_length_reg;
  assign irq_out                = irq_reg;
endmodule : ethernet_rx_frame_status
`default_nettype wire

/* rtl/phy_activity_if.sv */
// Activity summary passed from the PHY tracker to the status logic
`timescale 1ns/1ps
`default_nettype none
interface phy_activity_if;
  logic frame_active;
  logic code_err_now;
  logic code_err_seen;
  logic carrier_seen;
  logic clear_seen;
  modport tracker (output frame_active, code_err_now, code_err_seen, carrier_seen,
                   input clear_seen);
  modport status  (input frame_active, code_err_now, code_err_seen, carrier_seen,
                   output clear_seen);
endinterface : phy_activity_if
`default_nettype wire

/* rtl/phy_activity_tracker.sv */
// Synchronises PHY receive pins and keeps sticky activity flags
`timescale 1ns/1ps
`default_nettype none
module phy_activity_tracker (
  input  wire logic       clk_in,
  input  wire logic       rstn_in,
  input  wire logic       rx_dv_pin_in,
  input  wire logic       rx_er_pin_in,
  input  wire logic       crs_pin_in,
  phy_activity_if.tracker act
);
  logic [2:0] meta_reg;
  logic [2:0] sync_reg;
  logic [2:0] pins;
  logic       dv_s;
  logic       er_s;
  logic       crs_s;
  logic       crs_d_reg;
  logic       attempt_reg;
  logic       cv_reg;
  logic       carrier_reg;
  logic       carrier_end;

  assign pins = {crs_pin_in, rx_er_pin_in, rx_dv_pin_in};

  genvar i;
  generate
    for (i = 0; i < 3; i++) begin : g_sync
      always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
          meta_reg[i] <= 1'b0;
          sync_reg[i] <= 1'b0;
        end else begin
          meta_reg[i] <= pins[i];
          sync_reg[i] <= meta_reg[i];
        end
      end
    end
  endgenerate

  assign dv_s  = sync_reg[0];
  assign er_s  = sync_reg[1];
  assign crs_s = sync_reg[2];

  // Burst ended without any data valid: no receive attempt
  assign carrier_end = crs_d_reg && !crs_s && !attempt_reg;

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      crs_d_reg   <= 1'b0;
      attempt_reg <= 1'b0;
    end else begin
      crs_d_reg   <= crs_s;
      attempt_reg <= crs_s ? (attempt_reg | dv_s) : 1'b0;
    end
  end

  // New events win over the clear; they then belong to the next frame
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cv_reg      <= 1'b0;
      carrier_reg <= 1'b0;
    end else begin
      cv_reg      <= (dv_s && er_s) || (cv_reg && !act.clear_seen); // RL13
      carrier_reg <= carrier_end || (carrier_reg && !act.clear_seen); // RL5
    end
  end

  assign act.frame_active  = dv_s;
  assign act.code_err_now  = dv_s && er_s;
  assign act.code_err_seen = cv_reg;
  assign act.carrier_seen  = carrier_reg;
endmodule : phy_activity_tracker
`default_nettype wire

/* rtl/rx_status_pkg.sv */
// Constants for the receive frame status capture block
// How it works
// RL1 - Load status word, then flag buffer complete
// RL2 - DMA mode copies low half to descriptor
// RL3 - Upper half holds completed frame byte count
// RL4 - DMA mode writes byte count to descriptor
// RL5 - Carrier activity without attempt sets sticky flag
// RL6 - Missing preamble or delimiter sets sticky flag
// RL7 - Good frame raises ready until drained
// RL8 - Broadcast frame flagged and made ready
// RL9 - Multicast frame flagged and made ready
// RL10 - Failed frame check sets CRC flag
// RL11 - Error frame: no ready, flushed at once
// RL12 - One to seven extra bits flag dribble
// RL13 - Receive error during data sets violation
// RL14 - Long frames flagged, accepted only if enabled
// RL15 - Short frames flagged, accepted only if enabled
// RL16 - FIFO full during frame sets overflow
// RL17 - Status read-only, reserved and reset zero
package rx_status_pkg;
  localparam logic [31:0] STATUS_ADDR   = 32'hff80_0014;
  localparam logic [31:0] CTRL_ADDR     = 32'hff80_0018;
  localparam logic [31:0] IRQ_STAT_ADDR = 32'hff80_001c;
  localparam logic [31:0] IRQ_MASK_ADDR = 32'hff80_0020;

  localparam int COUNT_LSB     = 16;
  localparam int CARRIER_BIT   = 15;
  localparam int DATA_VIOL_BIT = 14;
  localparam int GOOD_BIT      = 13;
  localparam int BCAST_BIT     = 12;
  localparam int MCAST_BIT     = 11;
  localparam int FCS_BIT       = 10;
  localparam int DRIBBLE_BIT   = 9;
  localparam int CODE_BIT      = 8;
  localparam int LONG_BIT      = 7;
  localparam int SHORT_BIT     = 6;
  localparam int OVF_BIT       = 5;

  localparam int DMA_MODE_BIT  = 0;
  localparam int ACC_LONG_BIT  = 1;
  localparam int ACC_SHORT_BIT = 2;
  localparam int CTRL_W        = 3;

  localparam int IRQ_DONE_BIT  = 0;
  localparam int IRQ_GOOD_BIT  = 1;
  localparam int IRQ_FLUSH_BIT = 2;
  localparam int IRQ_W         = 3;

  localparam logic [31:0]       STATUS_RESET = 32'h0000_0000;
  localparam logic [CTRL_W-1:0] CTRL_RESET   = 3'h0;
  localparam logic [IRQ_W-1:0]  MASK_RESET   = 3'h0;

  // 1518 and 64 bytes
  localparam logic [15:0] MAX_FRAME_BYTES = 16'h05ee;
  localparam logic [15:0] MIN_FRAME_BYTES = 16'h0040;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage : rx_status_pkg

/* tb/ethernet_rx_frame_status_tb.sv */
// Self-checking bench for the receive frame status block
`timescale 1ns/1ps
`default_nettype none
module ethernet_rx_frame_status_tb;
  import rx_status_pkg::*;
  logic        clk_in, rstn_in;
  logic [31:0] s_axi_awaddr_in, s_axi_wdata_in, s_axi_araddr_in, s_axi_rdata_out;
  logic [3:0]  s_axi_wstrb_in;
  logic [1:0]  s_axi_bresp_out, s_axi_rresp_out;
  logic        s_axi_awvalid_in, s_axi_awready_out, s_axi_wvalid_in, s_axi_wready_out;
  logic        s_axi_bvalid_out, s_axi_bready_in, s_axi_arvalid_in, s_axi_arready_out;
  logic        s_axi_rvalid_out, s_axi_rready_in, rx_dv_pin_in, rx_er_pin_in, crs_pin_in;
  logic        frame_end_in, fcs_bad_in, dest_broadcast_in, dest_multicast_in;
  logic        sfd_missing_in, fifo_full_in, frame_drained_in;
  logic [15:0] frame_bytes_in, desc_status_out, desc_length_out;
  logic [2:0]  extra_bits_in;
  logic        receive_word_ready_out, receive_fifo_level_out, buffer_complete_out;
  logic        flush_frame_out, desc_write_out, irq_out;
  int          bad_count, n_compared, cyc;
  logic        dma;
  logic [31:0] desc_exp;

  ethernet_rx_frame_status u_dut (.*);
  phy_rx_model u_phy (.clk_in(clk_in), .rx_dv_out(rx_dv_pin_in), .rx_er_out(rx_er_pin_in),
                      .crs_out(crs_pin_in));

  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  task finish_test;
    if (bad_count == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : finish_test

  task check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : check

  function automatic logic [15:0] fb(input int i);
    return 16'h0001 << i;
  endfunction : fb

  // Address and data offered together, each dropped once taken
  task wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge clk_in);
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= d;
    s_axi_awvalid_in <= 1'b1;
    s_axi_wvalid_in <= 1'b1;
    s_axi_bready_in <= 1'b1;
    while (!(aw && w)) begin
      @(posedge clk_in);
      if (!aw && s_axi_awready_out) begin
        aw = 1'b1;
        s_axi_awvalid_in <= 1'b0;
      end
      if (!w && s_axi_wready_out) begin
        w = 1'b1;
        s_axi_wvalid_in <= 1'b0;
      end
    end
    while (!s_axi_bvalid_out) @(posedge clk_in);
    s_axi_bready_in <= 1'b0;
    check(32'(s_axi_bresp_out), 32'(er));
  endtask : wr

  task rd(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge clk_in);
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1'b1;
    s_axi_rready_in <= 1'b1;
    do @(posedge clk_in); while (!s_axi_arready_out);
    s_axi_arvalid_in <= 1'b0;
    while (!s_axi_rvalid_out) @(posedge clk_in);
    s_axi_rready_in <= 1'b0;
    check(s_axi_rdata_out, ed);
    check(32'(s_axi_rresp_out), 32'(er));
  endtask : rd

  // f is {fcs bad, broadcast, multicast}; good frames are drained at the end
  task fr(input logic [15:0] n, input logic [2:0] f, input logic [2:0] xb,
          input logic [15:0] ex, input logic good);
    @(posedge clk_in);
    frame_bytes_in <= n;
    {fcs_bad_in, dest_broadcast_in, dest_multicast_in} <= f;
    extra_bits_in <= xb;
    frame_end_in <= 1'b1;
    @(posedge clk_in);
    frame_end_in <= 1'b0;
    @(negedge clk_in);
    check(32'(receive_word_ready_out), 32'(good));
    check(32'(flush_frame_out), 32'(!good));
    if (dma) desc_exp = {n, ex};
    check(32'(desc_write_out), 32'(dma));
    check({desc_length_out, desc_status_out}, desc_exp);
    @(negedge clk_in);
    check(32'(buffer_complete_out), 32'h0000_0001);
    rd(STATUS_ADDR, {n, ex}, RESP_OKAY);
    if (good) begin
      @(posedge clk_in);
      frame_drained_in <= 1'b1;
      @(posedge clk_in);
      frame_drained_in <= 1'b0;
      @(negedge clk_in);
      check(32'(receive_fifo_level_out), 32'h0000_0000);
    end
  endtask : fr

  task t_regs;
    rd(STATUS_ADDR, 32'h0000_0000, RESP_OKAY);
    rd(CTRL_ADDR, 32'h0000_0000, RESP_OKAY);
    rd(32'hff80_0024, 32'h0000_0000, RESP_DECERR);
    wr(32'hff80_0024, 32'h0000_0001, RESP_DECERR);
    wr(STATUS_ADDR, 32'hffff_ffff, RESP_OKAY);
    rd(STATUS_ADDR, 32'h0000_0000, RESP_OKAY);
    wr(CTRL_ADDR, 32'h0000_0001, RESP_OKAY);
    dma = 1'b1;
    rd(CTRL_ADDR, 32'h0000_0001, RESP_OKAY);
  endtask : t_regs

  task t_good;
    wr(IRQ_MASK_ADDR, 32'h0000_0007, RESP_OKAY);
    fr(16'h0064, 3'h2, 3'h0, fb(GOOD_BIT) | fb(BCAST_BIT), 1'b1);
    check(32'(irq_out), 32'h0000_0001);
    rd(IRQ_STAT_ADDR, 32'h0000_0003, RESP_OKAY);
    rd(IRQ_STAT_ADDR, 32'h0000_0000, RESP_OKAY);
    check(32'(irq_out), 32'h0000_0000);
    wr(IRQ_MASK_ADDR, 32'h0000_0000, RESP_OKAY);
    // Without DMA the descriptor must hold the last copy
    wr(CTRL_ADDR, 32'h0000_0000, RESP_OKAY);
    dma = 1'b0;
    fr(16'h0064, 3'h1, 3'h0, fb(GOOD_BIT) | fb(MCAST_BIT), 1'b1);
    check(32'(irq_out), 32'h0000_0000);
    wr(CTRL_ADDR, 32'h0000_0001, RESP_OKAY);
    dma = 1'b1;
    rd(IRQ_STAT_ADDR, 32'h0000_0003, RESP_OKAY);
  endtask : t_good

  task t_errors;
    fr(16'h0064, 3'h4, 3'h0, fb(FCS_BIT), 1'b0);
    rd(IRQ_STAT_ADDR, 32'h0000_0005, RESP_OKAY);
    fr(16'h0064, 3'h0, 3'h1, fb(DRIBBLE_BIT), 1'b0);
    fr(16'h0064, 3'h0, 3'h7, fb(DRIBBLE_BIT), 1'b0);
    fr(16'h05ef, 3'h0, 3'h0, fb(LONG_BIT), 1'b0);
    fr(16'h05ee, 3'h0, 3'h0, fb(GOOD_BIT), 1'b1);
    fr(16'h003f, 3'h0, 3'h0, fb(SHORT_BIT), 1'b0);
    fr(16'h0040, 3'h0, 3'h0, fb(GOOD_BIT), 1'b1);
    wr(CTRL_ADDR, 32'h0000_0007, RESP_OKAY);
    fr(16'h05ef, 3'h0, 3'h0, fb(LONG_BIT) | fb(GOOD_BIT), 1'b1);
    fr(16'h003f, 3'h0, 3'h0, fb(SHORT_BIT) | fb(GOOD_BIT), 1'b1);
  endtask : t_errors

  // Pins pass a two-stage synchroniser, hence the settle gaps
  task t_phy;
    @(posedge clk_in);
    u_phy.carrier(5);
    repeat (4) @(posedge clk_in);
    fr(16'h0080, 3'h0, 3'h0, fb(CARRIER_BIT) | fb(GOOD_BIT), 1'b1);
    @(posedge clk_in);
    u_phy.frame(10, 1'b1);
    repeat (4) @(posedge clk_in);
    fr(16'h0080, 3'h0, 3'h0, fb(CODE_BIT), 1'b0);
    @(posedge clk_in);
    sfd_missing_in <= 1'b1;
    @(posedge clk_in);
    sfd_missing_in <= 1'b0;
    fr(16'h0080, 3'h0, 3'h0, fb(DATA_VIOL_BIT) | fb(GOOD_BIT), 1'b1);
    @(posedge clk_in);
    fork
      u_phy.frame(8, 1'b0);
      begin
        repeat (4) @(posedge clk_in);
        fifo_full_in <= 1'b1;
        @(posedge clk_in);
        fifo_full_in <= 1'b0;
      end
    join
    repeat (4) @(posedge clk_in);
    fr(16'h0080, 3'h0, 3'h0, fb(OVF_BIT), 1'b0);
  endtask : t_phy

  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      bad_count++;
      finish_test();
    end
  end

  initial begin
    bad_count = 0;
    n_compared = 0;
    cyc = 0;
    dma = 1'b0;
    desc_exp = 32'h0000_0000;
    rstn_in = 1'b0;
    s_axi_wstrb_in = 4'hf;
    {s_axi_awaddr_in, s_axi_wdata_in, s_axi_araddr_in, frame_bytes_in, extra_bits_in} = '0;
    {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in} = '0;
    {s_axi_rready_in, frame_end_in, fcs_bad_in, dest_broadcast_in, dest_multicast_in} = '0;
    {sfd_missing_in, fifo_full_in, frame_drained_in} = '0;
    repeat (8) @(posedge clk_in);
    rstn_in <= 1'b1;
    t_regs();
    t_good();
    t_errors();
    t_phy();
    finish_test();
  end
endmodule : ethernet_rx_frame_status_tb
`default_nettype wire

/* tb/phy_rx_model.sv */
// Behavioural receive side of the PHY
`timescale 1ns/1ps
`default_nettype none
module phy_rx_model (
  input  wire logic clk_in,
  output var logic  rx_dv_out,
  output var logic  rx_er_out,
  output var logic  crs_out
);
  initial begin
    rx_dv_out = 1'b0;
    rx_er_out = 1'b0;
    crs_out = 1'b0;
  end
  // Carrier with no data, so no receive attempt
  task carrier(input int n);
    crs_out <= 1'b1;
    repeat (n) @(posedge clk_in);
    crs_out <= 1'b0;
  endtask : carrier
  // Larger n models a longer frame; er marks bad codes in the data phase
  task frame(input int n, input logic er);
    crs_out <= 1'b1;
    rx_dv_out <= 1'b1;
    rx_er_out <= er;
    repeat (n) @(posedge clk_in);
    crs_out <= 1'b0;
    rx_dv_out <= 1'b0;
    rx_er_out <= 1'b0;
  endtask : frame
endmodule : phy_rx_model
`default_nettype wire

/* tb/rx_status_asserts.sv */
// Port-level checks for the receive frame status block
`timescale 1ns/1ps
`default_nettype none
module rx_status_asserts
  import rx_status_pkg::*;
(
  input wire logic        clk_in,
  input wire logic        rstn_in,
  input wire logic        frame_end_in,
  input wire logic [15:0] frame_bytes_in,
  input wire logic        fcs_bad_in,
  input wire logic [2:0]  extra_bits_in,
  input wire logic        dest_broadcast_in,
  input wire logic        frame_drained_in,
  input wire logic        receive_word_ready_out,
  input wire logic        receive_fifo_level_out,
  input wire logic        buffer_complete_out,
  input wire logic        flush_frame_out,
  input wire logic        desc_write_out,
  input wire logic [15:0] desc_status_out,
  input wire logic [15:0] desc_length_out,
  input wire logic        s_axi_arvalid_in,
  input wire logic        s_axi_arready_out,
  input wire logic        s_axi_rvalid_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  chk_done_follows: assert property (frame_end_in |-> ##2 buffer_complete_out)
    else $error("buffer complete missing after frame end");
  chk_done_cause: assert property (buffer_complete_out |-> $past(frame_end_in, 2))
    else $error("buffer complete without a frame");
  chk_desc_length: assert property (desc_write_out |->
    $past(frame_end_in) && desc_length_out == $past(frame_bytes_in))
    else $error("descriptor length wrong");
  chk_desc_flags: assert property (desc_write_out |->
    desc_status_out[FCS_BIT] == $past(fcs_bad_in) && desc_status_out[4:0] == 5'h00
    && desc_status_out[BCAST_BIT] == $past(dest_broadcast_in))
    else $error("descriptor status wrong");
  chk_fcs_flush: assert property (frame_end_in && fcs_bad_in |=> flush_frame_out)
    else $error("bad check sequence not flushed");
  chk_dribble_flush: assert property (frame_end_in && extra_bits_in != 3'h0 |=> flush_frame_out)
    else $error("dribble frame not flushed");
  chk_flush_cause: assert property (flush_frame_out |->
    $past(frame_end_in) && !$rose(receive_word_ready_out))
    else $error("flush without a bad frame");
  chk_ready_drop: assert property (frame_drained_in && !frame_end_in |=> !receive_word_ready_out)
    else $error("ready stayed after drain");
  chk_ready_pair: assert property (receive_word_ready_out == receive_fifo_level_out)
    else $error("ready and level differ");
  chk_ready_cause: assert property ($rose(receive_word_ready_out) |->
    $past(frame_end_in) && !flush_frame_out)
    else $error("ready rose without a good frame");
  chk_read_answer: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
    else $error("read not answered");
endmodule : rx_status_asserts
bind ethernet_rx_frame_status rx_status_asserts u_chk (.*);
`default_nettype wire
